// File: shared/uart_pkg.sv
/*
 * Constants and types of the serial channel.
 * Assumes nothing beyond a SystemVerilog-2012 tool.
 */
package uart_pkg;
    // FIFO depths
    localparam int unsigned DEPTH_HIGH_SPEED = 64;
    localparam int unsigned DEPTH_NORMAL = 16;
    // 16 oversampling ticks per bit
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_TICK = 4'h7;
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    localparam logic [2:0] DATA_LAST = 3'h7;
    localparam int unsigned NORMAL_DIV_ADD = 2;
    localparam logic [7:0] BREAK_EXTRA = 8'h02;
    // rx FIFO entry: {address, break, framing, parity, data}
    localparam int unsigned RX_W = 12;
    localparam int unsigned ERR_LSB = 8;
    localparam int unsigned ADDR_BIT = 11;
    // flag positions
    localparam int unsigned F_TX_EMPTY = 0;
    localparam int unsigned F_RX_THRESHOLD = 1;
    localparam int unsigned F_LINE_STATUS = 2;
    localparam int unsigned F_RX_TIMEOUT = 3;
    localparam int unsigned F_MODEM = 4;
    localparam int unsigned F_BUF_ERR = 5;
    localparam int unsigned F_LIN_BREAK = 6;
    localparam int unsigned N_FLAGS = 7;
    // reset values
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [6:0] FLAGS_RESET = 7'h00;
    localparam logic [7:0] CNT8_RESET = 8'h00;
    localparam logic [3:0] CNT4_RESET = 4'h0;

    typedef enum logic [1:0] {
        FN_UART = 2'h0,
        FN_LIN = 2'h1,
        FN_IRDA = 2'h2,
        FN_RS485 = 2'h3
    } func_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_START = 3'h1,
        TX_DATA = 3'h3,
        TX_PAR = 3'h2,
        TX_STOP = 3'h6,
        TX_HOLD = 3'h7,
        TX_BREAK = 3'h5
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h3,
        RX_PAR = 3'h2,
        RX_STOP = 3'h6
    } rx_state_t;
endpackage : uart_pkg

// File: core/fifo_mem.sv
/*
 * One FIFO's storage with a registered read port.
 * Assumes next cycle's read address; a write to it is forwarded.
 */
`timescale 1ns/10ps
`default_nettype none
module fifo_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (en && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (en) begin
            rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
        end
    end
endmodule : fifo_mem
`default_nettype wire

// File: core/uart_core.sv
/*
 * Serial channel with tx and rx FIFOs, event flags and three line
 * functions: infrared encode/decode, LIN break, RS-485 nine-bit.
 * Assumes all inputs synchronous to clk; config held steady mid-frame.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_core #(
    parameter int unsigned DEPTH = uart_pkg::DEPTH_NORMAL,
    parameter int unsigned AW = $clog2(DEPTH),
    parameter int unsigned DIV_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire uart_pkg::func_t function_select,
    input wire logic [DIV_W-1:0] baud_divider,
    input wire logic parity_enable,
    input wire logic even_parity_select,
    input wire logic stick_parity,
    input wire logic [3:0] break_length_field,
    input wire logic lin_tx_start,
    output logic lin_tx_enable,
    input wire logic lin_rx_enable,
    input wire logic normal_multidrop_mode,
    input wire logic auto_address_mode,
    input wire logic auto_direction_mode,
    input wire logic pre_address_rx_disable,
    input wire logic receiver_disable,
    input wire logic [7:0] addr_match,
    input wire logic [7:0] tx_turnaround_delay,
    input wire logic driver_enable_polarity,
    input wire logic rts_manual,
    input wire logic rx_invert,
    input wire logic [AW:0] rx_trigger_level,
    input wire logic [7:0] rx_timeout_bits,
    input wire logic [6:0] irq_enable,
    input wire logic [6:0] flag_clear,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic [2:0] rx_error,
    output logic rx_address,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [6:0] irq_flags,
    output logic irq,
    output logic transmitter_empty_flag,
    output logic txd,
    input wire logic rxd,
    output logic ir_tx,
    input wire logic ir_rx,
    output logic rts,
    input wire logic cts_n
);
    import uart_pkg::*;

    typedef struct packed {
        logic [DIV_W:0] div;
        tx_state_t tx_st;
        logic [3:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic [7:0] tx_cnt;
        logic txd;
        logic ir_tx;
        logic de;
        logic lin_tx_en;
        logic lin_run;
        logic te;
        rx_state_t rx_st;
        logic [3:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_nine;
        logic rx_prev;
        logic [3:0] ir_hold;
        logic seen_addr;
        logic match;
        logic cts_prev;
        logic [3:0] tout_tick;
        logic [7:0] tout_cnt;
        logic [6:0] flags;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [AW:0] tx_n;
        logic [AW:0] rx_n;
    } state_t;

    localparam state_t STATE_RESET = '{
        div: '0, tx_st: TX_IDLE, tx_tick: CNT4_RESET, tx_bit: '0,
        tx_sh: CNT8_RESET, tx_par: 1'b0, tx_cnt: CNT8_RESET,
        txd: LINE_IDLE, ir_tx: 1'b0, de: 1'b0, lin_tx_en: 1'b0,
        lin_run: 1'b0, te: 1'b1, rx_st: RX_IDLE, rx_tick: CNT4_RESET,
        rx_bit: '0, rx_sh: CNT8_RESET, rx_nine: 1'b0, rx_prev: LINE_IDLE,
        ir_hold: CNT4_RESET, seen_addr: 1'b0, match: 1'b0,
        cts_prev: 1'b1, tout_tick: CNT4_RESET, tout_cnt: CNT8_RESET,
        flags: FLAGS_RESET, tx_wp: '0, tx_rp: '0, rx_wp: '0, rx_rp: '0,
        tx_n: '0, rx_n: '0};

    state_t s_r;
    state_t s_nxt;
    logic [DIV_W:0] period;
    logic tick;
    logic tx_end;
    logic rx_end;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [RX_W-1:0] rx_word;
    logic [RX_W-1:0] rx_q;
    logic [7:0] tx_q;
    logic rx_line;
    logic ir_low;
    logic lin_mode;
    logic irda_mode;
    logic rs485_mode;
    logic fe;
    logic pe;
    logic brk;
    logic is_addr;
    logic store;
    logic [6:0] set_f;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // stick parity: bit is the inverse of even select
    function automatic logic parity_of(input logic [7:0] d,
                                       input logic even,
                                       input logic stick);
        parity_of = stick ? ~even : (even ? ^d : ~^d);
    endfunction : parity_of

    assign lin_mode = (function_select == FN_LIN);
    assign irda_mode = (function_select == FN_IRDA);
    assign rs485_mode = (function_select == FN_RS485);
    assign tx_ready = (s_r.tx_n != (AW + 1)'(DEPTH));
    assign rx_valid = (s_r.rx_n != '0);
    assign tx_push = tx_valid && tx_ready;
    assign rx_pop = rx_valid && rx_ready;
    assign rx_data = rx_q[7:0];
    assign rx_error = rx_q[ERR_LSB+2:ERR_LSB];
    assign rx_address = rx_q[ADDR_BIT];
    assign irq_flags = s_r.flags;
    assign irq = |(s_r.flags & irq_enable);
    assign transmitter_empty_flag = s_r.te;
    assign lin_tx_enable = s_r.lin_tx_en;
    assign txd = s_r.txd;
    assign ir_tx = s_r.ir_tx;
    // high enables the driver unless polarity is inverted
    assign rts = (auto_direction_mode ? s_r.de : rts_manual)
                 ^ driver_enable_polarity;
    // pulse-low input when inversion is set, as it is at idle
    assign ir_low = rx_invert ? ~ir_rx : ir_rx;
    assign rx_line = irda_mode ? (s_r.ir_hold == '0) : rxd;

    always_comb begin
        s_nxt = s_r;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_word = '0;
        set_f = '0;
        fe = 1'b0;
        pe = 1'b0;
        brk = 1'b0;
        is_addr = 1'b0;
        store = 1'b0;
        // 16x tick: divider+2 normally, divider alone in infrared
        period = {1'b0, baud_divider}
                 + (irda_mode ? '0 : (DIV_W + 1)'(NORMAL_DIV_ADD));
        tick = (period <= (DIV_W + 1)'(1)) || (s_r.div >= period - 1'b1);
        s_nxt.div = tick ? '0 : s_r.div + 1'b1;
        tx_end = tick && (s_r.tx_tick == TICK_LAST);
        rx_end = tick && (s_r.rx_tick == TICK_LAST);
        if (tick && s_r.tx_st != TX_IDLE) begin
            s_nxt.tx_tick = s_r.tx_tick + 4'h1;
        end
        if (lin_mode && lin_tx_start) begin
            s_nxt.lin_tx_en = 1'b1;
        end

        case (s_r.tx_st)
            TX_IDLE: begin
                s_nxt.tx_tick = CNT4_RESET;
                if (lin_mode && s_r.lin_tx_en) begin
                    s_nxt.tx_st = TX_BREAK;
                    s_nxt.tx_cnt = {4'h0, break_length_field}
                                   + BREAK_EXTRA;
                    s_nxt.txd = 1'b0;
                    s_nxt.de = 1'b1;
                end else if (s_r.tx_n != '0 && (!lin_mode || s_r.lin_run)
                             && !(irda_mode && s_r.rx_st != RX_IDLE)) begin
                    if (auto_direction_mode && !s_r.de) begin
                        s_nxt.de = 1'b1; // one cycle of lead
                    end else begin
                        tx_pop = 1'b1;
                        s_nxt.tx_sh = tx_q;
                        s_nxt.tx_par = parity_of(tx_q, even_parity_select,
                                                 stick_parity);
                        s_nxt.tx_st = TX_START;
                        s_nxt.txd = 1'b0;
                        s_nxt.de = 1'b1;
                    end
                end else if (s_r.tx_n == '0) begin
                    s_nxt.lin_run = 1'b0;
                end
            end
            TX_BREAK: begin
                if (tx_end) begin
                    s_nxt.tx_cnt = s_r.tx_cnt - 8'h01;
                    if (s_r.tx_cnt == 8'h01) begin
                        // delimiter bit, then queued bytes
                        s_nxt.lin_tx_en = 1'b0;
                        s_nxt.lin_run = 1'b1;
                        s_nxt.tx_st = TX_STOP;
                        s_nxt.txd = 1'b1;
                    end
                end
            end
            TX_START: begin
                if (tx_end) begin
                    s_nxt.tx_st = TX_DATA;
                    s_nxt.tx_bit = '0;
                    s_nxt.txd = s_r.tx_sh[0]; // lsb first
                end
            end
            TX_DATA: begin
                if (tx_end) begin
                    s_nxt.tx_sh = s_r.tx_sh >> 1;
                    s_nxt.tx_bit = s_r.tx_bit + 3'h1;
                    if (s_r.tx_bit != DATA_LAST) begin
                        s_nxt.txd = s_r.tx_sh[1];
                    end else if (parity_enable) begin
                        s_nxt.tx_st = TX_PAR;
                        s_nxt.txd = s_r.tx_par;
                    end else begin
                        s_nxt.tx_st = TX_STOP;
                        s_nxt.txd = 1'b1;
                    end
                end
            end
            TX_PAR: begin
                if (tx_end) begin
                    s_nxt.tx_st = TX_STOP;
                    s_nxt.txd = 1'b1;
                end
            end
            TX_STOP: begin
                if (tx_end) begin
                    s_nxt.tx_cnt = tx_turnaround_delay;
                    s_nxt.tx_st = (auto_direction_mode && s_r.tx_n == '0)
                                  ? TX_HOLD : TX_IDLE;
                end
            end
            TX_HOLD: begin
                // driver held for the delay in bit times
                if (s_r.tx_n != '0) begin
                    s_nxt.tx_st = TX_IDLE;
                end else if (s_r.tx_cnt == CNT8_RESET) begin
                    s_nxt.tx_st = TX_IDLE;
                    s_nxt.de = 1'b0;
                end else if (tx_end) begin
                    s_nxt.tx_cnt = s_r.tx_cnt - 8'h01;
                end
            end
            default: begin
                s_nxt.tx_st = TX_IDLE;
            end
        endcase
        if (!auto_direction_mode && s_nxt.tx_st == TX_IDLE) begin
            s_nxt.de = 1'b0;
        end
        // light pulse in the first 3 of 16 ticks of a zero
        s_nxt.ir_tx = irda_mode && s_nxt.tx_st != TX_IDLE && !s_nxt.txd
                      && s_nxt.tx_tick < IR_PULSE_TICKS;
        // set once tx is back in idle, after any turnaround hold, and nothing is queued
        s_nxt.te = (s_nxt.tx_st == TX_IDLE) && (s_r.tx_n == '0);

        // stretch each pulse to a bit; muted while sending
        if (irda_mode && ir_low && s_r.tx_st == TX_IDLE) begin
            s_nxt.ir_hold = TICK_LAST;
        end else if (tick && s_r.ir_hold != '0) begin
            s_nxt.ir_hold = s_r.ir_hold - 4'h1;
        end
        s_nxt.rx_prev = rx_line;
        if (tick && s_r.rx_st != RX_IDLE) begin
            s_nxt.rx_tick = s_r.rx_tick + 4'h1;
        end

        case (s_r.rx_st)
            RX_IDLE: begin
                s_nxt.rx_tick = CNT4_RESET;
                // a falling edge, so a held break does not retrigger
                if (!rx_line && s_r.rx_prev) begin
                    s_nxt.rx_st = RX_START;
                end
            end
            RX_START: begin
                if (tick && s_r.rx_tick == SAMPLE_TICK) begin
                    s_nxt.rx_tick = CNT4_RESET;
                    s_nxt.rx_bit = '0;
                    s_nxt.rx_st = rx_line ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_end) begin
                    s_nxt.rx_sh = {rx_line, s_r.rx_sh[7:1]};
                    s_nxt.rx_bit = s_r.rx_bit + 3'h1;
                    if (s_r.rx_bit == DATA_LAST) begin
                        s_nxt.rx_st = parity_enable ? RX_PAR : RX_STOP;
                        s_nxt.rx_nine = 1'b0;
                    end
                end
            end
            RX_PAR: begin
                if (rx_end) begin
                    s_nxt.rx_nine = rx_line;
                    s_nxt.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_end) begin
                    s_nxt.rx_st = RX_IDLE;
                    fe = !rx_line;
                    brk = fe && s_r.rx_sh == CNT8_RESET && !s_r.rx_nine;
                    is_addr = rs485_mode && parity_enable
                              && s_r.rx_nine;
                    pe = parity_enable && !stick_parity && !rs485_mode
                         && s_r.rx_nine != parity_of(s_r.rx_sh,
                                                     even_parity_select,
                                                     1'b0);
                    if (lin_mode && lin_rx_enable && brk) begin
                        set_f[F_LIN_BREAK] = 1'b1;
                    end else if (rs485_mode && auto_address_mode) begin
                        if (is_addr) begin
                            s_nxt.match = (s_r.rx_sh == addr_match);
                            store = (s_r.rx_sh == addr_match);
                        end else begin
                            store = s_r.match;
                        end
                    end else if (rs485_mode && normal_multidrop_mode) begin
                        if (is_addr) begin
                            s_nxt.seen_addr = 1'b1;
                            store = 1'b1;
                            set_f[F_LINE_STATUS] = 1'b1;
                        end else begin
                            store = !receiver_disable && (s_r.seen_addr
                                    || !pre_address_rx_disable);
                        end
                    end else begin
                        store = !receiver_disable;
                    end
                    if (store) begin
                        // error bits travel with the byte
                        rx_word = {is_addr, brk, fe, pe, s_r.rx_sh};
                        rx_push = (s_r.rx_n != (AW + 1)'(DEPTH));
                        set_f[F_BUF_ERR] = !rx_push;
                        set_f[F_LINE_STATUS] = set_f[F_LINE_STATUS]
                                               | pe | fe | brk;
                    end
                end
            end
            default: begin
                s_nxt.rx_st = RX_IDLE;
            end
        endcase

        // timeout counts idle bit times while data waits unread
        if (rx_push || rx_pop || s_r.rx_st != RX_IDLE || !rx_valid) begin
            s_nxt.tout_tick = CNT4_RESET;
            s_nxt.tout_cnt = CNT8_RESET;
        end else if (tick) begin
            s_nxt.tout_tick = s_r.tout_tick + 4'h1;
            if (s_r.tout_tick == TICK_LAST && s_r.tout_cnt != 8'hff) begin
                s_nxt.tout_cnt = s_r.tout_cnt + 8'h01;
            end
        end
        s_nxt.cts_prev = cts_n;
        set_f[F_MODEM] = (cts_n != s_r.cts_prev);

        // sticky flags, except tx empty, rx threshold and rx timeout: a set in the clearing cycle wins
        s_nxt.flags = set_f | (s_r.flags & ~flag_clear);
        s_nxt.flags[F_TX_EMPTY] = (s_nxt.tx_n == '0);
        s_nxt.flags[F_RX_THRESHOLD] = (rx_trigger_level != '0)
                                      && (s_nxt.rx_n >= rx_trigger_level);
        s_nxt.flags[F_RX_TIMEOUT] = (rx_timeout_bits != CNT8_RESET)
                                    && (s_r.tout_cnt >= rx_timeout_bits);

        if (tx_push) begin
            s_nxt.tx_wp = ptr_inc(s_r.tx_wp);
        end
        if (tx_pop) begin
            s_nxt.tx_rp = ptr_inc(s_r.tx_rp);
        end
        s_nxt.tx_n = s_r.tx_n + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
        if (rx_push) begin
            s_nxt.rx_wp = ptr_inc(s_r.rx_wp);
        end
        if (rx_pop) begin
            s_nxt.rx_rp = ptr_inc(s_r.rx_rp);
        end
        s_nxt.rx_n = s_r.rx_n + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= STATE_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) tx_mem (
        .clk(clk),
        .resetn(resetn),
        .en(ce),
        .we(tx_push),
        .waddr(s_r.tx_wp),
        .wdata(tx_data),
        .raddr(s_nxt.tx_rp),
        .rdata(tx_q)
    );

    fifo_mem #(.WIDTH(RX_W), .DEPTH(DEPTH), .AW(AW)) rx_mem (
        .clk(clk),
        .resetn(resetn),
        .en(ce),
        .we(rx_push),
        .waddr(s_r.rx_wp),
        .wdata(rx_word),
        .raddr(s_nxt.rx_rp),
        .rdata(rx_q)
    );
endmodule : uart_core
`default_nettype wire

// File: tb/uart_core_props.sv
/* uart_core port checker, bound below.
   assumes one clock domain and config held steady mid-frame */
`timescale 1ns/10ps
`default_nettype none
module uart_chk #(parameter int unsigned DIV_W = 16) (
    input wire logic clk, resetn, txd, ir_tx, rts, irq, lin_tx_enable,
    input wire logic transmitter_empty_flag, auto_direction_mode,
    input wire logic driver_enable_polarity, rts_manual,
    input wire uart_pkg::func_t function_select,
    input wire logic [DIV_W-1:0] baud_divider,
    input wire logic [3:0] break_length_field,
    input wire logic [6:0] irq_enable, flag_clear, irq_flags
);
    import uart_pkg::*;
    int low_n, ir_n, dv, bt, brk;
    assign dv = int'(baud_divider);
    assign bt = 16 * (dv + 2);
    assign brk = (int'(break_length_field) + 2) * bt;
    // run lengths of a low line and a high infrared pulse
    always_ff @(posedge clk) begin
        low_n <= txd ? 0 : low_n + 1;
        ir_n <= ir_tx ? ir_n + 1 : 0;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence s_brk_end;
        $rose(txd) && $past(lin_tx_enable);
    endsequence
    a_irq_merge: assert property (
        irq == |(irq_flags & irq_enable)) else $error("irq mismatch");
    a_brk_sticky: assert property (
        irq_flags[6] && !flag_clear[6] |=> irq_flags[6]) else $error("brk");
    a_brk_len: assert property (
        s_brk_end |-> low_n <= brk && low_n > brk - bt / 16) else $error("len");
    a_ir_width: assert property (
        $fell(ir_tx) |-> ir_n >= 2 * dv && ir_n <= 3 * dv) else $error("ir");
    a_ir_mode: assert property (
        $rose(ir_tx) |-> function_select == FN_IRDA) else $error("ir mode");
    a_idle_line: assert property (
        transmitter_empty_flag && function_select != FN_IRDA |-> txd)
        else $error("line not idle");
    a_rts_manual: assert property (
        !auto_direction_mode && !$past(auto_direction_mode) |->
        rts == (driver_enable_polarity ^ rts_manual)) else $error("rts");
    a_rts_lead: assert property (
        auto_direction_mode && $fell(txd) |-> rts != driver_enable_polarity)
        else $error("rts late");
endmodule : uart_chk
bind uart_core uart_chk #(.DIV_W(DIV_W)) chk (.*);
`default_nettype wire

// File: tb/remote_node.sv
/* far serial node: sends frames to the device, samples its line.
   the lines idle high as with a pull-up */
`timescale 1ns/10ps
`default_nettype none
module remote_node #(parameter int BIT = 64) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    logic [8:0] got = 9'h000;
    initial rxd = 1'h1;
    // start, data lsb first, optional ninth bit, stop
    task automatic send(input logic [8:0] pd, input bit nine, input logic s);
        logic [10:0] f;
        f = nine ? {s, pd, 1'h0} : {1'h1, s, pd[7:0], 1'h0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask : send
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk);
            got[i] = txd;
        end
    end
endmodule : remote_node
`default_nettype wire

// File: tb/tb_top.sv
/* bench for uart_core with remote_node on its line.
   assumes a 10 MHz clock and the default normal depth */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import uart_pkg::*;
    localparam int BIT = 64;
    logic clk, resetn, parity_enable, even_parity_select, stick_parity;
    logic lin_tx_start, lin_rx_enable, normal_multidrop_mode, tx_valid;
    logic auto_address_mode, auto_direction_mode, pre_address_rx_disable;
    logic receiver_disable, driver_enable_polarity, rx_ready;
    logic lin_tx_enable, tx_ready, rx_address, rx_valid, irq, txd, rxd, rts;
    logic transmitter_empty_flag, ir_tx;
    func_t function_select;
    logic [15:0] baud_divider;
    logic [3:0] break_length_field;
    logic [7:0] addr_match, tx_turnaround_delay, rx_timeout_bits, tx_data;
    logic [7:0] rx_data;
    logic [4:0] rx_trigger_level;
    logic [6:0] irq_enable, flag_clear, irq_flags;
    logic [2:0] rx_error;
    int num_errors = 0, checked = 0, cyc = 0, pulses = 0;
    uart_core dut (.ce(1'h1), .rts_manual(1'h0), .rx_invert(1'h1),
        .ir_rx(1'h1), .cts_n(1'h1), .*);
    remote_node #(.BIT(BIT)) peer (.clk(clk), .txd(txd), .rxd(rxd));
    always #50 clk = ~clk;
    always @(posedge ir_tx) pulses++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) stop_test(1'h1);
    end
    task automatic chk(input logic [8:0] g, e, input string m);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic push(input logic [7:0] d);
        tx_data <= d;
        tx_valid <= 1'h1;
        @(posedge clk);
        tx_valid <= 1'h0;
        repeat (2) @(posedge clk);
    endtask : push
    task automatic wait_for(input int w, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(posedge clk);
            if ((w == 0 ? transmitter_empty_flag : w == 1 ? rx_valid :
                !lin_tx_enable) === 1'h1) break;
        end
    endtask : wait_for
    task automatic pop_clear();
        rx_ready <= 1'h1;
        flag_clear <= 7'h7f;
        @(posedge clk);
        {rx_ready, flag_clear} <= 8'h00;
        repeat (2) @(posedge clk);
    endtask : pop_clear
    task automatic stop_test(input logic hung);
        if (hung) num_errors++;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    initial begin
        {parity_enable, even_parity_select, stick_parity, lin_tx_start,
         lin_rx_enable, normal_multidrop_mode, tx_valid, auto_address_mode,
         pre_address_rx_disable, receiver_disable, driver_enable_polarity,
         rx_ready, clk, resetn} = 14'h0000;
        {addr_match, rx_timeout_bits, tx_data, irq_enable} = 31'h0;
        {function_select, baud_divider, break_length_field} = 22'h00021;
        {tx_turnaround_delay, rx_trigger_level, flag_clear} = 20'h02080;
        auto_direction_mode = 1'h1;
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        function_select <= FN_RS485;
        {parity_enable, stick_parity} <= 2'h3;
        for (int e = 0; e < 2; e++) begin
            even_parity_select <= e[0];
            push(8'h3c);
            repeat (10 * BIT + BIT / 2) @(posedge clk);
            chk(peer.got, {~e[0], 8'h3c}, "nine");
            chk(rts, 1'h1, "rts on");
            repeat (3 * BIT) @(posedge clk);
            chk(rts, 1'h0, "rts off");
        end
        $display("rs485 tx done");
        // only the address byte may land in the fifo
        auto_direction_mode <= 1'h0;
        {normal_multidrop_mode, pre_address_rx_disable} <= 2'h3;
        peer.send(9'h011, 1, 1'h1);
        peer.send(9'h142, 1, 1'h1);
        wait_for(1, 4 * BIT);
        chk({rx_address, rx_data}, 9'h142, "addr");
        chk(irq_flags[F_LINE_STATUS], 1'h1, "addr flag");
        pop_clear();
        chk(rx_valid, 1'h0, "drop");
        $display("rs485 rx done");
        function_select <= FN_LIN;
        {parity_enable, stick_parity, normal_multidrop_mode} <= 3'h0;
        push(8'h55);
        push(8'h2a);
        lin_tx_start <= 1'h1;
        @(posedge clk);
        lin_tx_start <= 1'h0;
        wait_for(2, 8 * BIT);
        chk(lin_tx_enable, 1'h0, "self clear");
        wait_for(0, 24 * BIT);
        chk(irq_flags[F_TX_EMPTY], 1'h1, "drained");
        lin_rx_enable <= 1'h1;
        peer.send(9'h000, 0, 1'h0);
        chk({rx_valid, irq, irq_flags[6]}, 9'h001, "masked");
        irq_enable <= 7'h40;
        repeat (2) @(posedge clk);
        chk(irq, 1'h1, "brk irq");
        pop_clear();
        chk(irq, 1'h0, "cleared");
        $display("lin done");
        function_select <= FN_IRDA;
        {lin_rx_enable, baud_divider} <= 17'h00004;
        push(8'h00);
        wait_for(0, 16 * BIT);
        chk(pulses[8:0], 9'h009, "pulses");
        $display("irda done");
        stop_test(1'h0);
    end
endmodule : tb_top
`default_nettype wire
